// file: dv/rtcat_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_map.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; $display("Error %s exp %h got %h", n, e, g); end end

module rtcat_core_bench
	import rtcat_pkg::*;
;
	localparam logic [31:0] adr_tab [7] = '{`RTCAT_ADDR_CLOCK_CONTROL, `RTCAT_ADDR_TICK_CONTROL,
		`RTCAT_ADDR_ALARM_CONTROL, `RTCAT_ADDR_ALARM_SECOND, `RTCAT_ADDR_ALARM_MINUTE, `RTCAT_ADDR_ALARM_HOUR,
		`RTCAT_ADDR_ALARM_DATE};
	// Control already holds the access enable written just before the sweep
	localparam logic [7:0] rst_tab [7] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
	localparam logic [7:0] msk_tab [7] = '{8'h0F, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h3F};
	localparam logic [7:0] rr_tab [7] = '{8'h0B, 8'h0C, 8'h0D, 8'h08, 8'h0F, 8'h0C, 8'h04};
	localparam logic [7:0] sec_tab [7] = '{8'h47, 8'h47, 8'h47, 8'h47, 8'h47, 8'h40, 8'h47};
	localparam logic car_tab [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic power_off_mode = 1'b0;
	logic [7:0] cur_second = 8'h00;
	logic [7:0] cur_rest = 8'h00;
	logic [31:0] bus_addr;
	logic bus_wr;
	logic bus_rd;
	rtcat_byte_t bus_wdata;
	rtcat_byte_t bus_rdata;
	rtcat_byte_t d;
	logic count_step, count_chain_reset, counter_merge_select, count_clock_select;
	logic round_clear_seconds, round_carry_minute, alarm_irq, power_wakeup_request, tick_irq;
	int err_total = 0;
	int tests_run = 0;
	int n;

	always #2 clk = ~clk;

	rtcat_cpu_model u_cpu (.clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata);
	rtcat_core u_dut (.clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .xtal_tick(1'b1),
		.power_off_mode, .cur_second, .cur_minute(cur_rest), .cur_hour(cur_rest), .cur_date(cur_rest),
		.cur_month(cur_rest), .cur_year(cur_rest), .count_step, .count_chain_reset, .counter_merge_select,
		.count_clock_select, .round_clear_seconds, .round_carry_minute, .alarm_irq, .power_wakeup_request,
		.tick_irq);

	task automatic end_of_test;
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Bounded wait; a whole second of crystal steps is the longest gap
	task automatic wait_for(input bit alarm_side, output int c);
		c = 0;
		do
		begin
			@(negedge clk);
			c++;
		end
		while ((alarm_side ? count_step : tick_irq) !== 1'b1 && c < 40000);
		if (c >= 40000)
			err_total++;
	endtask

	initial
	begin
		repeat (6) @(negedge clk);
		sys_rst = 1'b0;
		u_cpu.rd(`RTCAT_ADDR_ALARM_DATE, d);
		`CHK("gated read", 8'h00, d)
		u_cpu.wr(`RTCAT_ADDR_TICK_CONTROL, 8'h85);
		u_cpu.wr(`RTCAT_ADDR_CLOCK_CONTROL, 8'h01);
		for (int i = 0; i < 7; i++)
		begin
			u_cpu.rd(adr_tab[i], d);
			`CHK("reset value", rst_tab[i], d)
			u_cpu.wr(adr_tab[i], 8'hFF);
			u_cpu.rd(adr_tab[i], d);
			`CHK("masked value", msk_tab[i], d)
		end
		`CHK("control outputs", 3'h7, {count_chain_reset, counter_merge_select, count_clock_select})
		u_cpu.rd(32'h57000048, d);
		`CHK("unmapped read", 8'h00, d)
		u_cpu.wr(`RTCAT_ADDR_CLOCK_CONTROL, 8'h01);
		`CHK("control cleared", 3'h0, {count_chain_reset, counter_merge_select, count_clock_select})
		for (int i = 0; i < 7; i++)
		begin
			cur_second = sec_tab[i];
			u_cpu.wr(`RTCAT_ADDR_ROUND_RESET, rr_tab[i]);
			`CHK("round clear", rr_tab[i][3], round_clear_seconds)
			`CHK("round carry", car_tab[i], round_carry_minute)
		end
		// Count 2 would tick within this span if the enable were ignored
		u_cpu.wr(`RTCAT_ADDR_TICK_CONTROL, 8'h02);
		repeat (1000) @(negedge clk) `CHK("tick masked", 1'b0, tick_irq)
		u_cpu.wr(`RTCAT_ADDR_TICK_CONTROL, 8'h82);
		wait_for(1'b0, n);
		wait_for(1'b0, n);
		`CHK("tick period", 768, n)
		u_cpu.wr(`RTCAT_ADDR_TICK_CONTROL, 8'h00);
		u_cpu.wr(`RTCAT_ADDR_ALARM_SECOND, 8'h12);
		u_cpu.wr(`RTCAT_ADDR_ALARM_CONTROL, 8'h41);
		cur_second = 8'h12;
		for (int i = 0; i < 2; i++)
		begin
			power_off_mode = i[0];
			wait_for(1'b1, n);
			if (i == 1)
				`CHK("second period", 32766, n)
			repeat (2) @(negedge clk);
			`CHK("alarm", 1'b1, alarm_irq)
			`CHK("wakeup", i[0], power_wakeup_request)
		end
		end_of_test();
	end

	initial
	begin
		#400000;
		err_total++;
		end_of_test();
	end
endmodule

`default_nettype wire

// file: dv/rtcat_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module rtcat_cpu_model
	import rtcat_pkg::*;
(
	input wire logic clk,
	output logic [31:0] bus_addr,
	output logic bus_wr,
	output logic bus_rd,
	output logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata
);
	initial
	begin
		bus_addr = 32'h00000000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		bus_wdata = 8'h00;
	end

	// Released lines show the inverse, so a stale value never passes
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge clk);
		bus_wr = 1'b0;
		bus_addr = ~a;
		bus_wdata = ~d;
	endtask

	task automatic rd(input logic [31:0] a, output logic [7:0] d);
		@(negedge clk);
		bus_addr = a;
		bus_rd = 1'b1;
		@(negedge clk);
		bus_rd = 1'b0;
		bus_addr = ~a;
		d = bus_rdata;
	endtask
endmodule

`default_nettype wire

// file: dv/rtcat_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_map.svh"

module rtcat_properties
	import rtcat_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] cur_second,
	input wire logic count_step,
	input wire logic count_chain_reset,
	input wire logic counter_merge_select,
	input wire logic count_clock_select,
	input wire logic round_clear_seconds,
	input wire logic round_carry_minute,
	input wire logic alarm_irq,
	input wire logic power_wakeup_request,
	input wire logic tick_irq
);
	logic acc_ff;
	logic tick_en_ff;
	logic alm_en_ff;
	wire logic wr_ctl = bus_wr && bus_addr == `RTCAT_ADDR_CLOCK_CONTROL;
	wire logic wr_ok = bus_wr && acc_ff;
	wire logic rr_go = wr_ok && bus_addr == `RTCAT_ADDR_ROUND_RESET && bus_wdata[3];
	wire logic car_exp = (bus_wdata[2:0] inside {3'h3, 3'h4, 3'h5}) && cur_second > {1'b0, bus_wdata[2:0], 4'h0};

	// Shadow of the enables, only as far as the assertions need them
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc_ff <= 1'b0;
			tick_en_ff <= 1'b0;
			alm_en_ff <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
				acc_ff <= bus_wdata[0];
			if (wr_ok && bus_addr == `RTCAT_ADDR_TICK_CONTROL)
				tick_en_ff <= bus_wdata[7];
			if (wr_ok && bus_addr == `RTCAT_ADDR_ALARM_CONTROL)
				alm_en_ff <= bus_wdata[6];
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_round_req;
		rr_go;
	endsequence
	sequence s_round_act;
		round_clear_seconds && round_carry_minute == $past(car_exp);
	endsequence

	a_round_action: assert property (s_round_req |=> s_round_act)
		else $error("round action wrong");
	a_round_idle: assert property (!rr_go |=> !round_clear_seconds && !round_carry_minute)
		else $error("round pulse without request");
	a_ctl_bits: assert property (wr_ctl |=> {count_chain_reset, counter_merge_select, count_clock_select} == $past(bus_wdata[3:1]))
		else $error("control outputs wrong");
	a_read_gate: assert property (bus_rd && !acc_ff && bus_addr != `RTCAT_ADDR_CLOCK_CONTROL |=> bus_rdata == 8'h00)
		else $error("gated read not zero");
	a_alarm_rsvd: assert property (bus_rd && bus_addr == `RTCAT_ADDR_ALARM_CONTROL |=> !bus_rdata[7])
		else $error("alarm control bit 7 set");
	a_alarm_step: assert property (alarm_irq |-> $past(count_step, 2) && !count_clock_select)
		else $error("alarm off the second update");
	a_alarm_gate: assert property (alarm_irq |-> alm_en_ff || $past(alm_en_ff))
		else $error("alarm while disabled");
	a_wake_pair: assert property (power_wakeup_request |-> alarm_irq)
		else $error("wakeup without alarm");
	a_tick_gate: assert property (tick_irq |-> (tick_en_ff || $past(tick_en_ff)) ##1 !tick_irq)
		else $error("tick pulse wrong");
endmodule

bind rtcat_core rtcat_properties u_props (.clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
	.cur_second, .count_step, .count_chain_reset, .counter_merge_select, .count_clock_select,
	.round_clear_seconds, .round_carry_minute, .alarm_irq, .power_wakeup_request, .tick_irq);

`default_nettype wire

// file: rtl/rtcat_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_map.svh"

module rtcat_core
	import rtcat_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic xtal_tick,
	input wire logic power_off_mode,
	input wire logic [7:0] cur_second,
	input wire logic [7:0] cur_minute,
	input wire logic [7:0] cur_hour,
	input wire logic [7:0] cur_date,
	input wire logic [7:0] cur_month,
	input wire logic [7:0] cur_year,
	output logic count_step,
	output logic count_chain_reset,
	output logic counter_merge_select,
	output logic count_clock_select,
	output logic round_clear_seconds,
	output logic round_carry_minute,
	output logic alarm_irq,
	output logic power_wakeup_request,
	output logic tick_irq
);

	rtcat_byte_t clock_control_ff;
	rtcat_byte_t tick_count_control_ff;
	rtcat_byte_t alarm_control_ff;
	rtcat_byte_t alarm_second_ff;
	rtcat_byte_t alarm_minute_ff;
	rtcat_byte_t alarm_hour_ff;
	rtcat_byte_t alarm_date_ff;
	rtcat_byte_t alarm_month_ff;
	rtcat_byte_t alarm_year_ff;
	rtcat_byte_t round_reset_register_ff;
	rtcat_byte_t bus_rdata_ff;
	rtcat_byte_t nxt_bus_rdata;
	rtcat_byte_t round_bound;
	rtcat_tick_t tick_work_ff;
	logic tick_irq_ff;
	logic alarm_irq_ff;
	logic wakeup_ff;
	logic step_eval_ff;
	logic count_step_ff;
	logic round_clear_ff;
	logic round_carry_ff;
	logic step_128hz;
	logic step_1hz;
	logic cpu_access_enable;
	logic wr_ok;
	logic rd_ok;
	logic wr_tick;
	logic wr_round;
	logic round_has_carry;
	logic all_match;

	// Control register stays reachable so software can open the gate at all
	assign cpu_access_enable = clock_control_ff[`RTCAT_CC_ACCESS_BIT];
	assign wr_ok = bus_wr && cpu_access_enable;
	assign rd_ok = bus_rd && cpu_access_enable;
	assign wr_tick = wr_ok && (bus_addr == `RTCAT_ADDR_TICK_CONTROL);
	assign wr_round = wr_ok && (bus_addr == `RTCAT_ADDR_ROUND_RESET);

	assign count_chain_reset = clock_control_ff[`RTCAT_CC_CHAINRST_BIT];
	assign counter_merge_select = clock_control_ff[`RTCAT_CC_MERGE_BIT];
	assign count_clock_select = clock_control_ff[`RTCAT_CC_CLK_SELECT_BIT];

	rtcat_prescaler u_prescaler
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.xtal_tick(xtal_tick),
		.clear(count_chain_reset),
		.step_128hz(step_128hz),
		.step_1hz(step_1hz)
	);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			clock_control_ff <= `RTCAT_RST_ZERO;
		else if (bus_wr && (bus_addr == `RTCAT_ADDR_CLOCK_CONTROL))
			clock_control_ff <= bus_wdata & `RTCAT_MASK_CLOCK_CONTROL;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tick_count_control_ff <= `RTCAT_RST_ZERO;
		else if (wr_tick)
			tick_count_control_ff <= bus_wdata & `RTCAT_MASK_TICK_CONTROL;
	end

	// Alarm field registers; reserved bits are masked off on write
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			alarm_control_ff <= `RTCAT_RST_ZERO;
			alarm_second_ff <= `RTCAT_RST_ZERO;
			alarm_minute_ff <= `RTCAT_RST_ZERO;
			alarm_hour_ff <= `RTCAT_RST_ZERO;
			alarm_date_ff <= `RTCAT_RST_ALARM_DATE;
			alarm_month_ff <= `RTCAT_RST_ALARM_MONTH;
			alarm_year_ff <= `RTCAT_RST_ZERO;
		end
		else if (wr_ok)
		begin
			case (bus_addr)
				`RTCAT_ADDR_ALARM_CONTROL: alarm_control_ff <= bus_wdata & `RTCAT_MASK_ALARM_CONTROL;
				`RTCAT_ADDR_ALARM_SECOND: alarm_second_ff <= bus_wdata & `RTCAT_MASK_SEC_MIN;
				`RTCAT_ADDR_ALARM_MINUTE: alarm_minute_ff <= bus_wdata & `RTCAT_MASK_SEC_MIN;
				`RTCAT_ADDR_ALARM_HOUR: alarm_hour_ff <= bus_wdata & `RTCAT_MASK_HOUR_DATE;
				`RTCAT_ADDR_ALARM_DATE: alarm_date_ff <= bus_wdata & `RTCAT_MASK_HOUR_DATE;
				`RTCAT_ADDR_ALARM_MONTH: alarm_month_ff <= bus_wdata & `RTCAT_MASK_MONTH;
				`RTCAT_ADDR_ALARM_YEAR: alarm_year_ff <= bus_wdata & `RTCAT_MASK_YEAR;
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			round_reset_register_ff <= `RTCAT_RST_ZERO;
		else if (wr_round)
			round_reset_register_ff <= bus_wdata & `RTCAT_MASK_ROUND_RESET;
	end

	// Read mux; the tick working count has no read path on purpose
	always_comb
	begin
		nxt_bus_rdata = `RTCAT_RST_ZERO;
		if (bus_addr == `RTCAT_ADDR_CLOCK_CONTROL)
			nxt_bus_rdata = clock_control_ff;
		else if (rd_ok)
		begin
			case (bus_addr)
				`RTCAT_ADDR_TICK_CONTROL: nxt_bus_rdata = tick_count_control_ff;
				`RTCAT_ADDR_ALARM_CONTROL: nxt_bus_rdata = alarm_control_ff;
				`RTCAT_ADDR_ALARM_SECOND: nxt_bus_rdata = alarm_second_ff;
				`RTCAT_ADDR_ALARM_MINUTE: nxt_bus_rdata = alarm_minute_ff;
				`RTCAT_ADDR_ALARM_HOUR: nxt_bus_rdata = alarm_hour_ff;
				`RTCAT_ADDR_ALARM_DATE: nxt_bus_rdata = alarm_date_ff;
				`RTCAT_ADDR_ALARM_MONTH: nxt_bus_rdata = alarm_month_ff;
				`RTCAT_ADDR_ALARM_YEAR: nxt_bus_rdata = alarm_year_ff;
				`RTCAT_ADDR_ROUND_RESET: nxt_bus_rdata = round_reset_register_ff;
				default: nxt_bus_rdata = `RTCAT_RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			bus_rdata_ff <= `RTCAT_RST_ZERO;
		else if (bus_rd)
			bus_rdata_ff <= nxt_bus_rdata;
	end

	assign bus_rdata = bus_rdata_ff;

	// Count step for the outside BCD chain: one per second or raw crystal for test
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			count_step_ff <= 1'b0;
		else if (count_clock_select)
			count_step_ff <= xtal_tick && !count_chain_reset;
		else
			count_step_ff <= step_1hz;
	end

	assign count_step = count_step_ff;

	// Tick down-counter; a write reloads at once so a new period starts cleanly
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tick_work_ff <= `RTCAT_TICK_ZERO;
		else if (wr_tick)
			tick_work_ff <= bus_wdata[`RTCAT_TICK_CNT_MSB:0];
		else if (step_128hz)
		begin
			if (tick_work_ff == `RTCAT_TICK_ZERO)
				tick_work_ff <= tick_count_control_ff[`RTCAT_TICK_CNT_MSB:0];
			else
				tick_work_ff <= tick_work_ff - `RTCAT_TICK_ONE;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			tick_irq_ff <= 1'b0;
		else
			tick_irq_ff <= step_128hz && !wr_tick && (tick_work_ff == `RTCAT_TICK_ONE)
				&& tick_count_control_ff[`RTCAT_TICK_EN_BIT];
	end

	assign tick_irq = tick_irq_ff;

	// Round reset: compare BCD seconds directly, BCD order matches numeric order
	always_comb
	begin
		round_bound = `RTCAT_RST_ZERO;
		round_has_carry = 1'b0;
		case (bus_wdata[`RTCAT_RR_CODE_MSB:0])
			`RTCAT_RR_CODE_30:
			begin
				round_bound = `RTCAT_BOUND_30;
				round_has_carry = 1'b1;
			end
			`RTCAT_RR_CODE_40:
			begin
				round_bound = `RTCAT_BOUND_40;
				round_has_carry = 1'b1;
			end
			`RTCAT_RR_CODE_50:
			begin
				round_bound = `RTCAT_BOUND_50;
				round_has_carry = 1'b1;
			end
			default:
			begin
				round_bound = `RTCAT_RST_ZERO;
				round_has_carry = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			round_clear_ff <= 1'b0;
			round_carry_ff <= 1'b0;
		end
		else
		begin
			round_clear_ff <= wr_round && bus_wdata[`RTCAT_RR_EN_BIT];
			round_carry_ff <= wr_round && bus_wdata[`RTCAT_RR_EN_BIT] && round_has_carry
				&& (cur_second > round_bound);
		end
	end

	assign round_clear_seconds = round_clear_ff;
	assign round_carry_minute = round_carry_ff;

	// Outside counters settle one cycle after the step, so compare then
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			step_eval_ff <= 1'b0;
		else
			step_eval_ff <= count_step_ff && !count_clock_select;
	end

	assign all_match =
		(!alarm_control_ff[`RTCAT_AC_YEAR_BIT] || (alarm_year_ff == cur_year)) &&
		(!alarm_control_ff[`RTCAT_AC_MONTH_BIT] || (alarm_month_ff == cur_month)) &&
		(!alarm_control_ff[`RTCAT_AC_DATE_BIT] || (alarm_date_ff == cur_date)) &&
		(!alarm_control_ff[`RTCAT_AC_HOUR_BIT] || (alarm_hour_ff == cur_hour)) &&
		(!alarm_control_ff[`RTCAT_AC_MINUTE_BIT] || (alarm_minute_ff == cur_minute)) &&
		(!alarm_control_ff[`RTCAT_AC_SECOND_BIT] || (alarm_second_ff == cur_second));

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			alarm_irq_ff <= 1'b0;
			wakeup_ff <= 1'b0;
		end
		else
		begin
			alarm_irq_ff <= step_eval_ff && all_match
				&& alarm_control_ff[`RTCAT_AC_GLOBAL_BIT];
			wakeup_ff <= step_eval_ff && all_match && power_off_mode
				&& alarm_control_ff[`RTCAT_AC_GLOBAL_BIT];
		end
	end

	assign alarm_irq = alarm_irq_ff;
	assign power_wakeup_request = wakeup_ff;

endmodule
`default_nettype wire

// file: rtl/rtcat_map.svh
`ifndef RTCAT_MAP_SVH
`define RTCAT_MAP_SVH

// Byte addresses of the register slots
`define RTCAT_ADDR_CLOCK_CONTROL 32'h57000040
`define RTCAT_ADDR_TICK_CONTROL 32'h57000044
`define RTCAT_ADDR_ALARM_CONTROL 32'h57000050
`define RTCAT_ADDR_ALARM_SECOND 32'h57000054
`define RTCAT_ADDR_ALARM_MINUTE 32'h57000058
`define RTCAT_ADDR_ALARM_HOUR 32'h5700005C
`define RTCAT_ADDR_ALARM_DATE 32'h57000060
`define RTCAT_ADDR_ALARM_MONTH 32'h57000064
`define RTCAT_ADDR_ALARM_YEAR 32'h57000068
`define RTCAT_ADDR_ROUND_RESET 32'h5700006C

// Reset values
`define RTCAT_RST_ZERO 8'h00
`define RTCAT_RST_ALARM_DATE 8'h01
`define RTCAT_RST_ALARM_MONTH 8'h01

// Writable bit masks, reserved bits read zero
`define RTCAT_MASK_CLOCK_CONTROL 8'h0F
`define RTCAT_MASK_TICK_CONTROL 8'hFF
`define RTCAT_MASK_ALARM_CONTROL 8'h7F
`define RTCAT_MASK_SEC_MIN 8'h7F
`define RTCAT_MASK_HOUR_DATE 8'h3F
`define RTCAT_MASK_MONTH 8'h1F
`define RTCAT_MASK_YEAR 8'hFF
`define RTCAT_MASK_ROUND_RESET 8'h0F

// Field positions
`define RTCAT_CC_ACCESS_BIT 0
`define RTCAT_CC_CLK_SELECT_BIT 1
`define RTCAT_CC_MERGE_BIT 2
`define RTCAT_CC_CHAINRST_BIT 3
`define RTCAT_TICK_EN_BIT 7
`define RTCAT_TICK_CNT_MSB 6
`define RTCAT_AC_GLOBAL_BIT 6
`define RTCAT_AC_YEAR_BIT 5
`define RTCAT_AC_MONTH_BIT 4
`define RTCAT_AC_DATE_BIT 3
`define RTCAT_AC_HOUR_BIT 2
`define RTCAT_AC_MINUTE_BIT 1
`define RTCAT_AC_SECOND_BIT 0
`define RTCAT_RR_EN_BIT 3
`define RTCAT_RR_CODE_MSB 2

// Round boundary codes and their BCD second values
`define RTCAT_RR_CODE_30 3'h3
`define RTCAT_RR_CODE_40 3'h4
`define RTCAT_RR_CODE_50 3'h5
`define RTCAT_BOUND_30 8'h30
`define RTCAT_BOUND_40 8'h40
`define RTCAT_BOUND_50 8'h50

// Crystal prescaler: 2^15 to one second, 2^8 to 1/128 s
`define RTCAT_PRESC_WIDTH 15
`define RTCAT_TICK_DIV_BITS 8
`define RTCAT_TICK_ZERO 7'h00
`define RTCAT_TICK_ONE 7'h01

`endif

// file: rtl/rtcat_pkg.sv
`default_nettype none
`include "rtcat_map.svh"

package rtcat_pkg;

	typedef logic [7:0] rtcat_byte_t;
	typedef logic [6:0] rtcat_tick_t;
	typedef logic [`RTCAT_PRESC_WIDTH-1:0] rtcat_presc_t;

endpackage
`default_nettype wire

// file: rtl/rtcat_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "rtcat_map.svh"

module rtcat_prescaler
	import rtcat_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic xtal_tick,
	input wire logic clear,
	output logic step_128hz,
	output logic step_1hz
);

	rtcat_presc_t div_ff;
	logic step_128hz_ff;
	logic step_1hz_ff;

	// Chain reset holds the divider at zero so the next second starts clean
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			div_ff <= '0;
		else if (clear)
			div_ff <= '0;
		else if (xtal_tick)
			div_ff <= div_ff + 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			step_128hz_ff <= 1'b0;
			step_1hz_ff <= 1'b0;
		end
		else
		begin
			step_128hz_ff <= !clear && xtal_tick && (&div_ff[`RTCAT_TICK_DIV_BITS-1:0]);
			step_1hz_ff <= !clear && xtal_tick && (&div_ff);
		end
	end

	assign step_128hz = step_128hz_ff;
	assign step_1hz = step_1hz_ff;

endmodule
`default_nettype wire
